//--- logic/fsw_status_ctrl.v
// How it works
// RULE1 - Latch is set only by enable command 06h, never by written data.
// RULE2 - Status read 05h returns volatile copy.
// RULE3 - Busy reads 1 during internal operations.
// RULE4 - While busy, only read/reset/suspend accepted.
// RULE5 - Busy clears on completion, pass or fail.
// RULE6 - Enable command 06h sets latch; gates writes.
// RULE7 - Program and erase need prior write enable.
// RULE8 - Non-volatile and info writes need enable.
// RULE9 - Volatile write uses 50h, latch untouched.
// RULE10 - Disable or operation completion clears latch.
// RULE11 - Pointer write C0h needs no enable.
// RULE12 - Protect bits have volatile and non-volatile cells.
// RULE13 - Writes to protected region are inhibited.
// RULE14 - Whole erase needs all protect bits zero.
// RULE15 - Quad enable turns control pins into data.
// RULE16 - Program suspended flag follows suspend/resume.
// RULE17 - Erase suspended flag follows suspend/resume.
// RULE18 - Info lock bits are one-time settable.
// RULE19 - Complement bit 14 inverts protected region.
// RULE20 - Protection error set on violation, reset clears.
// RULE21 - Failure flag set when operation fails.
// RULE22 - Drive field selects read output strength.
// RULE23 - Pin select bit chooses hold or reset.
// RULE24 - Low status byte layout, defaults zero.
// RULE25 - Register protect bits lock status writes.
// RULE26 - Unenabled status write changes nothing.
`timescale 1ns/10ps
`include "fsw_status_regs.vh"

module fsw_status_ctrl #(
    parameter PROG_CYC = 16,
    parameter ERASE_CYC = 64,
    parameter REG_CYC = 8,
    parameter CNT_W = 16
) (
    // Clock and reset.
    input wire i_clk,
    input wire i_rst,
    // Serial link pins, all asynchronous to i_clk.
    input wire i_sck,
    input wire i_cs_n,
    input wire i_si,
    input wire i_wp_n,
    input wire i_hold_rst_n,
    // Result from the array engine on the same clock.
    input wire i_op_fail,
    // Serial data out.
    output wire o_so,
    output wire o_so_oe,
    // Configuration and state seen by the pad ring and array.
    output wire o_busy,
    output wire [1:0] o_drive_strength,
    output wire o_quad_mode,
    output wire o_hold_active,
    output wire [7:0] o_pointer_setting
);

    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_RUN = 2'b01;
    localparam [1:0] ST_SUSP = 2'b10;
    localparam [1:0] KIND_PROG = 2'b00;
    localparam [1:0] KIND_ERASE = 2'b01;
    localparam [1:0] KIND_REG = 2'b10;
    // Timer loads, cut to the counter width on purpose; a count above the width wraps.
    localparam [CNT_W-1:0] PROG_LOAD = PROG_CYC - 1;
    localparam [CNT_W-1:0] ERASE_LOAD = ERASE_CYC - 1;
    localparam [CNT_W-1:0] REG_LOAD = REG_CYC - 1;

    // ****************************************************************
    // Decoding helpers.
    // ****************************************************************

    // Protected-region decode from protect field and complement bit.
    function prot_hit;
        input [4:0] bp;
        input cmp;
        input [23:0] addr;
        reg [23:0] span;
        reg hit;
        begin
            span = `FSW_SPAN_SMALL;
            hit = 1'b0;
            if (bp[2:0] == 3'h7) begin
                hit = 1'b1;
            end else if (bp[2:0] != 3'h0) begin
                if (!bp[4]) begin
                    span = `FSW_SPAN_BIG << (bp[2:0] - 3'h1);
                end else if (bp[2]) begin
                    span = `FSW_SPAN_HALF;
                end else begin
                    span = `FSW_SPAN_SMALL << (bp[1:0] - 2'h1);
                end
                if (bp[3]) begin
                    hit = {1'b0, addr[22:0]} < span;
                end else begin
                    hit = {1'b0, addr[22:0]} >= (`FSW_ARRAY_TOP - span);
                end
            end
            prot_hit = hit ^ cmp; // see RULE13 see RULE19
        end
    endfunction

    // Merge one written byte into a configuration image.
    function [23:0] merge_byte;
        input [23:0] old;
        input [7:0] data;
        input [1:0] idx;
        input otp;
        reg [23:0] bm;
        reg [23:0] nw;
        begin
            bm = (`FSW_BYTE_MASK << {idx, 3'b000}) & `FSW_CFG_MASK;
            nw = (old & ~bm) | ({data, data, data} & bm);
            if (otp) begin
                merge_byte = nw | (old & `FSW_LOCK_MASK); // see RULE18
            end else begin
                merge_byte = (nw & ~`FSW_LOCK_MASK) | (old & `FSW_LOCK_MASK);
            end
        end
    endfunction

    // Commands that a busy device still takes.
    function quiet_cmd;
        input [7:0] op;
        begin
            quiet_cmd = (op == `FSW_CMD_STAT_RD_LOW) || (op == `FSW_CMD_STAT_RD_MID) ||
                (op == `FSW_CMD_STAT_RD_HIGH) || (op == `FSW_CMD_SOFT_RESET) ||
                (op == `FSW_CMD_SUSPEND);
        end
    endfunction

    // ****************************************************************
    // Pin synchronisers and edge detection.
    // ****************************************************************

    reg [4:0] meta_ff;
    reg [4:0] sync_ff;
    reg sck_q_ff;
    reg cs_q_ff;

    // Two stages; only the second stage feeds any logic.
    always @(posedge i_clk) begin
        if (i_rst) begin
            meta_ff <= 5'h1e;
            sync_ff <= 5'h1e;
            sck_q_ff <= 1'b0;
            cs_q_ff <= 1'b1;
        end else begin
            meta_ff <= {i_hold_rst_n, i_wp_n, i_si, i_cs_n, i_sck};
            sync_ff <= meta_ff;
            sck_q_ff <= sync_ff[0];
            cs_q_ff <= sync_ff[1];
        end
    end

    reg [23:0] vcfg_ff;
    reg [23:0] nv_ff;
    wire quad_on = vcfg_ff[`FSW_BIT_QUAD];
    wire pin_low = !sync_ff[4];
    // Pin roles follow quad enable and pin select.
    wire hold_now = !quad_on && !vcfg_ff[`FSW_BIT_PINSEL] && pin_low; // see RULE15 see RULE23
    wire hw_rst = !quad_on && vcfg_ff[`FSW_BIT_PINSEL] && pin_low; // see RULE23
    // Write protect pin only counts while it is not a data line.
    wire wp_low = !quad_on && !sync_ff[3]; // see RULE15
    wire sck_rise = sync_ff[0] && !sck_q_ff && !hold_now;
    wire sck_fall = !sync_ff[0] && sck_q_ff && !hold_now;
    wire cs_low = !sync_ff[1];
    wire cs_rise = sync_ff[1] && !cs_q_ff;

    // ****************************************************************
    // Frame shifter.
    // ****************************************************************

    reg [2:0] bit_cnt_ff;
    reg [2:0] byte_cnt_ff;
    reg [7:0] shift_ff;
    reg [7:0] opc_ff;
    reg [7:0] dat_ff;
    reg [23:0] addr_ff;
    wire [7:0] byte_in = {shift_ff[6:0], sync_ff[2]};

    // Bytes are counted to seven and then held, which is enough for decode.
    always @(posedge i_clk) begin
        if (i_rst || !cs_low) begin
            bit_cnt_ff <= 3'h0;
            byte_cnt_ff <= 3'h0;
            shift_ff <= 8'h00;
            if (i_rst) begin
                opc_ff <= 8'h00;
                dat_ff <= 8'h00;
                addr_ff <= 24'h000000;
            end
        end else if (sck_rise) begin
            shift_ff <= byte_in;
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7) begin
                if (byte_cnt_ff != 3'h7) begin
                    byte_cnt_ff <= byte_cnt_ff + 3'h1;
                end
                if (byte_cnt_ff == 3'h0) begin
                    opc_ff <= byte_in;
                end
                if (byte_cnt_ff == 3'h1) begin
                    dat_ff <= byte_in;
                end
                if (byte_cnt_ff != 3'h0 && byte_cnt_ff < 3'h4) begin
                    addr_ff <= {addr_ff[15:0], byte_in};
                end
            end
        end
    end

    // ****************************************************************
    // Status assembly and read-back.
    // ****************************************************************

    reg [1:0] op_state_ff;
    reg [1:0] op_kind_ff;
    reg wel_ff;
    reg vwen_ff;
    reg perr_ff;
    reg fail_ff;
    reg [23:0] status_word;
    reg [7:0] rd_byte;
    reg rd_op;

    // The read path shows the volatile copy, never the stored image.
    always @* begin
        status_word = vcfg_ff & `FSW_CFG_MASK; // see RULE2 see RULE24
        status_word[`FSW_BIT_BUSY] = op_state_ff == ST_RUN; // see RULE3
        status_word[`FSW_BIT_WEL] = wel_ff;
        status_word[`FSW_BIT_PROGRAM_SUSPENDED_FLAG] = op_state_ff == ST_SUSP && op_kind_ff == KIND_PROG; // see RULE16
        status_word[`FSW_BIT_ERASE_SUSPENDED_FLAG] = op_state_ff == ST_SUSP && op_kind_ff == KIND_ERASE; // see RULE17
        status_word[`FSW_BIT_PROTECTION_ERROR_FLAG] = perr_ff;
        status_word[`FSW_BIT_FAIL] = fail_ff;
        rd_op = 1'b1;
        if (opc_ff == `FSW_CMD_STAT_RD_LOW) begin
            rd_byte = status_word[7:0];
        end else if (opc_ff == `FSW_CMD_STAT_RD_MID) begin
            rd_byte = status_word[15:8];
        end else if (opc_ff == `FSW_CMD_STAT_RD_HIGH) begin
            rd_byte = status_word[23:16];
        end else begin
            rd_byte = 8'h00;
            rd_op = 1'b0;
        end
    end

    reg so_ff;
    reg so_oe_ff;
    wire reading = cs_low && byte_cnt_ff != 3'h0 && rd_op && !hold_now;

    // Data leaves on the falling edge; the byte repeats while the host clocks.
    always @(posedge i_clk) begin
        if (i_rst) begin
            so_ff <= 1'b0;
            so_oe_ff <= 1'b0;
        end else begin
            so_oe_ff <= reading;
            if (reading && sck_fall) begin
                so_ff <= rd_byte[~bit_cnt_ff];
            end
        end
    end

    // ****************************************************************
    // Command execution and the internal operation timer.
    // ****************************************************************

    reg [CNT_W-1:0] op_cnt_ff;
    reg [23:0] pend_ff;
    reg [7:0] ptr_ff;
    wire frame_ok = cs_rise && bit_cnt_ff == 3'h0 && byte_cnt_ff != 3'h0;
    wire busy = op_state_ff == ST_RUN;
    wire accept = frame_ok && (!busy || quiet_cmd(opc_ff)); // see RULE4
    wire [4:0] bp = vcfg_ff[`FSW_BP_HI:`FSW_BP_LO];
    wire [1:0] srp = {vcfg_ff[`FSW_BIT_SRP_HI], vcfg_ff[`FSW_BIT_SRP_LO]};
    // Register protection: 01 with pin low, or any upper setting, locks.
    wire sr_locked = srp[1] || (srp[0] && wp_low); // see RULE25
    wire hit = prot_hit(bp, vcfg_ff[`FSW_BIT_CMP], addr_ff);
    wire [1:0] info_idx = addr_ff[11:10];
    wire [2:0] locks = vcfg_ff[`FSW_LOCK_HI:`FSW_LOCK_LO];
    wire info_locked = info_idx == 2'h3 || locks[info_idx]; // see RULE18
    wire [1:0] wr_idx = opc_ff == `FSW_CMD_STAT_WR_LOW ? 2'h0 :
        opc_ff == `FSW_CMD_STAT_WR_MID ? 2'h1 : 2'h2;
    wire [23:0] nv_new = merge_byte(nv_ff, dat_ff, wr_idx, 1'b1);
    wire [23:0] vol_new = merge_byte(vcfg_ff, dat_ff, wr_idx, 1'b0);
    wire addr_cmd = byte_cnt_ff >= 3'h4 && op_state_ff == ST_IDLE;
    wire is_prog = opc_ff == `FSW_CMD_PAGE_PROG || opc_ff == `FSW_CMD_QUAD_PROG;
    wire is_erase = opc_ff == `FSW_CMD_SECT_ERASE || opc_ff == `FSW_CMD_HALF_ERASE ||
        opc_ff == `FSW_CMD_FULL_ERASE;
    wire is_wr = opc_ff == `FSW_CMD_STAT_WR_LOW || opc_ff == `FSW_CMD_STAT_WR_MID ||
        opc_ff == `FSW_CMD_STAT_WR_HIGH;
    wire is_info = opc_ff == `FSW_CMD_INFO_PROG || opc_ff == `FSW_CMD_INFO_ERASE;
    wire is_chip = opc_ff == `FSW_CMD_ARRAY_ERASE_A || opc_ff == `FSW_CMD_ARRAY_ERASE_B;

    // Clears come before sets so that an event in the same cycle is kept.
    always @(posedge i_clk) begin
        if (i_rst) begin
            nv_ff <= `FSW_CFG_RESET; // see RULE12
            vcfg_ff <= `FSW_CFG_RESET;
            pend_ff <= `FSW_CFG_RESET;
            op_state_ff <= ST_IDLE;
            op_kind_ff <= KIND_PROG;
            op_cnt_ff <= {CNT_W{1'b0}};
            wel_ff <= 1'b0;
            vwen_ff <= 1'b0;
            perr_ff <= 1'b0;
            fail_ff <= 1'b0;
            ptr_ff <= 8'h00;
        end else if (hw_rst) begin
            // Reset pin aborts work and reloads the volatile copy.
            vcfg_ff <= nv_ff;
            op_state_ff <= ST_IDLE;
            wel_ff <= 1'b0;
            vwen_ff <= 1'b0;
            perr_ff <= 1'b0; // see RULE20
            fail_ff <= 1'b0;
        end else begin
            if (busy) begin
                if (op_cnt_ff == {CNT_W{1'b0}}) begin
                    op_state_ff <= ST_IDLE; // see RULE5
                    wel_ff <= 1'b0; // see RULE10
                    if (op_kind_ff == KIND_REG) begin
                        nv_ff <= pend_ff;
                        vcfg_ff <= pend_ff;
                    end
                    if (i_op_fail) begin
                        fail_ff <= 1'b1; // see RULE21
                    end
                end else begin
                    op_cnt_ff <= op_cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
            if (accept) begin
                // A volatile-write enable lasts for exactly the next command.
                vwen_ff <= opc_ff == `FSW_CMD_VOL_WRITE_EN; // see RULE9
                if (opc_ff == `FSW_CMD_WRITE_EN) begin
                    wel_ff <= 1'b1; // see RULE1 see RULE6
                end else if (opc_ff == `FSW_CMD_WRITE_DIS) begin
                    wel_ff <= 1'b0; // see RULE10
                end else if (opc_ff == `FSW_CMD_SOFT_RESET) begin
                    vcfg_ff <= nv_ff;
                    op_state_ff <= ST_IDLE;
                    wel_ff <= 1'b0;
                    vwen_ff <= 1'b0;
                    perr_ff <= 1'b0; // see RULE20
                    // A failure reported in this same cycle still sets the flag.
                    fail_ff <= busy && op_cnt_ff == {CNT_W{1'b0}} && i_op_fail; // see RULE21
                end else if (opc_ff == `FSW_CMD_SUSPEND) begin
                    if (busy && op_kind_ff != KIND_REG && op_cnt_ff != {CNT_W{1'b0}}) begin
                        op_state_ff <= ST_SUSP; // see RULE16 see RULE17
                    end
                end else if (opc_ff == `FSW_CMD_RESUME) begin
                    if (op_state_ff == ST_SUSP) begin
                        op_state_ff <= ST_RUN;
                    end
                end else if (opc_ff == `FSW_CMD_POINTER_WR) begin
                    if (byte_cnt_ff >= 3'h2) begin
                        ptr_ff <= dat_ff; // see RULE11
                    end
                end else if (is_wr && byte_cnt_ff >= 3'h2 && !sr_locked) begin
                    // The latch bit itself is never taken from the data.
                    if (vwen_ff) begin
                        vcfg_ff <= vol_new; // see RULE9 see RULE1
                    end else if (wel_ff) begin
                        if (nv_new == nv_ff) begin
                            // Identical data is not rewritten into the cells.
                            vcfg_ff <= nv_new;
                            wel_ff <= 1'b0;
                        end else begin
                            pend_ff <= nv_new; // see RULE8 see RULE12
                            op_kind_ff <= KIND_REG;
                            op_cnt_ff <= REG_LOAD;
                            op_state_ff <= ST_RUN; // see RULE3
                        end
                    end
                    // No latch and no pending enable: nothing moves.   see RULE26
                end else if ((is_prog || is_erase) && addr_cmd && wel_ff) begin // see RULE7
                    if (hit) begin
                        perr_ff <= 1'b1; // see RULE13 see RULE20
                    end else begin
                        op_kind_ff <= is_prog ? KIND_PROG : KIND_ERASE;
                        op_cnt_ff <= is_prog ? PROG_LOAD : ERASE_LOAD;
                        op_state_ff <= ST_RUN;
                    end
                end else if (is_info && addr_cmd && wel_ff) begin // see RULE8
                    if (info_locked) begin
                        perr_ff <= 1'b1;
                    end else begin
                        op_kind_ff <= opc_ff == `FSW_CMD_INFO_PROG ? KIND_PROG : KIND_ERASE;
                        op_cnt_ff <= opc_ff == `FSW_CMD_INFO_PROG ? PROG_LOAD : ERASE_LOAD;
                        op_state_ff <= ST_RUN;
                    end
                end else if (is_chip && wel_ff && op_state_ff == ST_IDLE) begin // see RULE7
                    if (bp == 5'h00) begin // see RULE14
                        op_kind_ff <= KIND_ERASE;
                        op_cnt_ff <= ERASE_LOAD;
                        op_state_ff <= ST_RUN;
                    end
                end
            end
        end
    end

    // ****************************************************************
    // Outputs, all taken from flip-flops.
    // ****************************************************************

    assign o_so = so_ff;
    assign o_so_oe = so_oe_ff;
    assign o_busy = op_state_ff[0];
    assign o_drive_strength = vcfg_ff[`FSW_DRV_HI:`FSW_DRV_LO]; // see RULE22
    assign o_quad_mode = vcfg_ff[`FSW_BIT_QUAD]; // see RULE15
    assign o_pointer_setting = ptr_ff;

    reg hold_ff;

    // Registered hold indication for the pad logic.
    always @(posedge i_clk) begin
        if (i_rst) begin
            hold_ff <= 1'b0;
        end else begin
            hold_ff <= hold_now;
        end
    end

    assign o_hold_active = hold_ff;

endmodule // fsw_status_ctrl

//--- logic/fsw_status_regs.vh
`ifndef FSW_STATUS_REGS_VH
`define FSW_STATUS_REGS_VH

// ****************************************************************
// Command codes seen on the serial link.
// ****************************************************************
`define FSW_CMD_WRITE_EN      8'h06
`define FSW_CMD_WRITE_DIS     8'h04
`define FSW_CMD_VOL_WRITE_EN  8'h50
`define FSW_CMD_STAT_WR_LOW   8'h01
`define FSW_CMD_STAT_WR_MID   8'h31
`define FSW_CMD_STAT_WR_HIGH  8'h11
`define FSW_CMD_STAT_RD_LOW   8'h05
`define FSW_CMD_STAT_RD_MID   8'h35
`define FSW_CMD_STAT_RD_HIGH  8'h15
`define FSW_CMD_PAGE_PROG     8'h02
`define FSW_CMD_QUAD_PROG     8'h32
`define FSW_CMD_SECT_ERASE    8'h20
`define FSW_CMD_HALF_ERASE    8'h52
`define FSW_CMD_FULL_ERASE    8'hd8
`define FSW_CMD_ARRAY_ERASE_A 8'hc7
`define FSW_CMD_ARRAY_ERASE_B 8'h60
`define FSW_CMD_INFO_ERASE    8'h44
`define FSW_CMD_INFO_PROG     8'h42
`define FSW_CMD_POINTER_WR    8'hc0
`define FSW_CMD_SUSPEND       8'h75
`define FSW_CMD_RESUME        8'h7a
`define FSW_CMD_SOFT_RESET    8'h99

// ****************************************************************
// Status word bit positions (low, mid and high bytes).
// ****************************************************************
`define FSW_BIT_BUSY     0
`define FSW_BIT_WEL      1
`define FSW_BP_LO        2
`define FSW_BP_HI        6
`define FSW_BIT_SRP_LO   7
`define FSW_BIT_SRP_HI   8
`define FSW_BIT_QUAD     9
`define FSW_BIT_PROGRAM_SUSPENDED_FLAG     10
`define FSW_LOCK_LO      11
`define FSW_LOCK_HI      13
`define FSW_BIT_CMP      14
`define FSW_BIT_ERASE_SUSPENDED_FLAG     15
`define FSW_BIT_PROTECTION_ERROR_FLAG 18
`define FSW_BIT_FAIL     19
`define FSW_DRV_LO       21
`define FSW_DRV_HI       22
`define FSW_BIT_PINSEL   23

// ****************************************************************
// Masks, reset value and protection spans.
// ****************************************************************
`define FSW_CFG_MASK    24'he07bfc
`define FSW_LOCK_MASK   24'h003800
`define FSW_BYTE_MASK   24'h0000ff
`define FSW_CFG_RESET   24'h400000
`define FSW_SPAN_BIG    24'h020000
`define FSW_SPAN_SMALL  24'h001000
`define FSW_SPAN_HALF   24'h008000
`define FSW_ARRAY_TOP   24'h800000

`endif

//--- verif/fsw_status_ctrl_sva.sv
`timescale 1ns/10ps
// ****
// Port checks.
// ****
module fsw_status_ctrl_sva #(
    parameter PROG_CYC = 16,
    parameter ERASE_CYC = 64,
    parameter REG_CYC = 8
) (
    // Clock, reset and link pins.
    input wire i_clk,
    input wire i_rst,
    input wire i_cs_n,
    input wire i_hold_rst_n,
    // Outputs.
    input wire o_so_oe,
    input wire o_busy,
    input wire [1:0] o_drive_strength,
    input wire o_quad_mode,
    input wire o_hold_active,
    input wire [7:0] o_pointer_setting
);
    reg [15:0] run_ff;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Busy run length, so each busy run is checked against the program, erase and register lengths.
    always @(posedge i_clk) begin
        run_ff <= (i_rst || !o_busy) ? 16'h0000 : run_ff + 16'h0001;
    end
    a_reset_values: assert property (@(posedge i_clk) disable iff (1'b0) i_rst |=> !o_busy && !o_so_oe
        && !o_quad_mode && o_drive_strength == 2'b10 && o_pointer_setting == 8'h00) else $error("bad reset values");
    a_busy_after_frame: assert property ($rose(o_busy) |-> i_cs_n && $past(i_cs_n, 2))
        else $error("busy rose inside a frame");
    a_so_idle_off: assert property (i_cs_n [*6] |-> !o_so_oe) else $error("output on while idle");
    a_so_frame_on: assert property (o_so_oe |-> !$past(i_cs_n, 5)) else $error("output outside a frame");
    a_pointer_frame: assert property ($changed(o_pointer_setting) |-> i_cs_n)
        else $error("pointer moved inside a frame");
    a_busy_length: assert property ($fell(o_busy) |-> run_ff == PROG_CYC || run_ff == ERASE_CYC
        || run_ff == REG_CYC) else $error("busy run length wrong");
    a_busy_minimum: assert property ($rose(o_busy) |=> o_busy [*3]) else $error("busy too short");
    a_hold_cause: assert property (o_hold_active |-> !$past(i_hold_rst_n, 3))
        else $error("hold without pin");
    c_busy: cover property ($rose(o_busy));
    c_read: cover property ($rose(o_so_oe));
    c_hold: cover property (o_hold_active);
endmodule // fsw_status_ctrl_sva

bind fsw_status_ctrl fsw_status_ctrl_sva #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC), .REG_CYC(REG_CYC))
    i_fsw_status_ctrl_sva (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_hold_rst_n(i_hold_rst_n),
    .o_so_oe(o_so_oe), .o_busy(o_busy), .o_drive_strength(o_drive_strength), .o_quad_mode(o_quad_mode),
    .o_hold_active(o_hold_active), .o_pointer_setting(o_pointer_setting));

//--- verif/fsw_host.sv
`timescale 1ns/10ps
// ****
// Link host, mode 0, whole bytes only.
// ****
module fsw_host (
    // Link pins.
    output reg o_sck,
    output reg o_cs_n,
    output reg o_si,
    input wire i_so
);
    // Clock stands still between frames.
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end
    // Sends n bytes from the top of d; rd keeps the last byte seen on the data out line.
    task xfer(input [31:0] d, input integer n, output [7:0] rd);
        integer i;
        begin
            o_cs_n = 1'b0;
            for (i = 0; i < 8 * n; i = i + 1) begin
                o_si = d[31 - i];
                #62.5 o_sck = 1'b1;
                rd = {rd[6:0], i_so};
                #62.5 o_sck = 1'b0;
            end
            #62.5 o_cs_n = 1'b1;
            // Released data line shows the inverse, so no stale value looks valid.
            o_si = ~o_si;
            #100;
        end
    endtask
endmodule // fsw_host

//--- verif/fsw_status_ctrl_bench.sv
`timescale 1ns/10ps
// ****
// Bench for the status and write-enable logic.
// ****
module fsw_status_ctrl_bench;
    reg i_clk, i_rst, i_wp_n, i_hold_rst_n, i_op_fail;
    wire sck, cs_n, si, o_so, o_so_oe, o_busy, o_quad_mode, o_hold_active;
    wire [1:0] o_drive_strength;
    wire [7:0] o_pointer_setting;
    integer miscompares = 0;
    integer cmp_count = 0;
    integer cycles = 0;
    reg [7:0] rd;
    // Long program time so the busy bit can be read mid-operation.
    fsw_status_ctrl #(.PROG_CYC(600), .ERASE_CYC(40), .REG_CYC(20)) i_fsw_status_ctrl (.i_clk(i_clk),
        .i_rst(i_rst), .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .i_wp_n(i_wp_n), .i_hold_rst_n(i_hold_rst_n),
        .i_op_fail(i_op_fail), .o_so(o_so), .o_so_oe(o_so_oe), .o_busy(o_busy),
        .o_drive_strength(o_drive_strength), .o_quad_mode(o_quad_mode), .o_hold_active(o_hold_active),
        .o_pointer_setting(o_pointer_setting));
    fsw_host i_fsw_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(o_so));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // Cuts a hang short.
    always @(posedge i_clk) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            miscompares = miscompares + 1;
            finish_test;
        end
    end
    task check(input [63:0] what, input [7:0] exp, input [7:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("MISMATCH %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task cmd(input [7:0] op);
        i_fsw_host.xfer({op, 24'h0}, 1, rd);
    endtask
    task wr(input [7:0] op, input [7:0] d);
        i_fsw_host.xfer({op, d, 16'h0}, 2, rd);
    endtask
    task rs(input [7:0] op);
        i_fsw_host.xfer({op, 24'h0}, 2, rd);
    endtask
    task wait_idle;
        integer n;
        begin
            for (n = 0; n < 2000 && o_busy !== 1'b0; n = n + 1) @(posedge i_clk);
            @(negedge i_clk);
            if (o_busy !== 1'b0) begin
                miscompares = miscompares + 1;
                $display("MISMATCH idle expected 0 seen %b", o_busy);
            end
        end
    endtask
    task t_reset;
        begin
            rs(8'h05); check("low", 8'h00, rd);
            rs(8'h35); check("mid", 8'h00, rd);
            rs(8'h15); check("high", 8'h40, rd);
            check("drive", 8'h02, {6'h0, o_drive_strength});
            cmd(8'h06); rs(8'h05); check("wel", 8'h02, rd);
            cmd(8'h04); rs(8'h05); check("wel", 8'h00, rd);
            $display("test reset done");
        end
    endtask
    task t_prog;
        begin
            @(negedge i_clk) i_op_fail = 1'b1;
            wr(8'h01, 8'h04); rs(8'h05); check("nowel", 8'h00, rd);
            i_fsw_host.xfer({8'h02, 24'h000100}, 4, rd); check("busy", 8'h00, {7'h0, o_busy});
            cmd(8'h06); i_fsw_host.xfer({8'h02, 24'h000100}, 4, rd);
            check("busy", 8'h01, {7'h0, o_busy});
            rs(8'h05); check("midop", 8'h03, rd);
            wr(8'hc0, 8'h5a); check("ptr", 8'h00, o_pointer_setting);
            wait_idle;
            rs(8'h05); check("done", 8'h00, rd);
            rs(8'h15); check("fail", 8'h48, rd);
            wr(8'hc0, 8'h5a); check("ptr", 8'h5a, o_pointer_setting);
            @(negedge i_clk) i_op_fail = 1'b0;
            $display("test program done");
        end
    endtask
    task t_vol;
        begin
            cmd(8'h50); wr(8'h01, 8'h06); rs(8'h05); check("vol", 8'h04, rd);
            cmd(8'h06); i_fsw_host.xfer({8'h20, 24'h7f0000}, 4, rd);
            check("busy", 8'h00, {7'h0, o_busy});
            rs(8'h15); check("prot", 8'h4c, rd);
            cmd(8'h06); cmd(8'hc7); check("busy", 8'h00, {7'h0, o_busy});
            cmd(8'h50); wr(8'h01, 8'h80); @(negedge i_clk) i_wp_n = 1'b0;
            cmd(8'h50); wr(8'h01, 8'h84); rs(8'h05); check("srplock", 8'h82, rd);
            @(negedge i_clk) i_wp_n = 1'b1;
            cmd(8'h99); rs(8'h15); check("clr", 8'h40, rd);
            rs(8'h05); check("reload", 8'h00, rd);
            $display("test volatile done");
        end
    endtask
    task t_nonvol;
        begin
            cmd(8'h06); wr(8'h31, 8'h0a); check("busy", 8'h01, {7'h0, o_busy});
            wait_idle; rs(8'h35); check("mid", 8'h0a, rd);
            check("quad", 8'h01, {7'h0, o_quad_mode});
            cmd(8'h06); wr(8'h31, 8'h00); wait_idle; rs(8'h35); check("lock", 8'h08, rd);
            check("quad", 8'h00, {7'h0, o_quad_mode});
            cmd(8'h06); wr(8'h11, 8'h20); wait_idle; check("drive", 8'h01, {6'h0, o_drive_strength});
            @(negedge i_clk) i_hold_rst_n = 1'b0;
            repeat (8) @(negedge i_clk);
            check("hold", 8'h01, {7'h0, o_hold_active});
            i_hold_rst_n = 1'b1;
            $display("test nonvolatile done");
        end
    endtask
    task finish_test;
        begin
            $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
            if (miscompares == 0 && cmp_count > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // Main sequence.
    initial begin
        i_rst = 1'b1;
        i_wp_n = 1'b1;
        i_hold_rst_n = 1'b1;
        i_op_fail = 1'b0;
        repeat (4) @(posedge i_clk);
        @(negedge i_clk) i_rst = 1'b0;
        repeat (5) @(negedge i_clk);
        t_reset;
        t_prog;
        t_vol;
        t_nonvol;
        finish_test;
    end
endmodule // fsw_status_ctrl_bench
